// ### hdl/pst_consts.vh
// constants for the pattern/state trigger qualifier
`ifndef PST_CONSTS_VH
`define PST_CONSTS_VH
`define PST_NUM_IN        4
`define PST_CLK_PERIOD_PS 5000
`define PST_QUAL_MIN_PS   10000
`define PST_QUAL_MAX_MS   5000
// shortest and longest qualifier in sampling cycles, sized for the 30-bit count
`define PST_QUAL_MIN_CYC  30'h2
`define PST_QUAL_MAX_CYC  30'h3b9aca00
`define PST_DUR_SAT       30'h3b9aca01
`define PST_CNT_W         30
`define PST_MODE_ENTER    3'h0
`define PST_MODE_EXIT     3'h1
`define PST_MODE_LONGER   3'h2
`define PST_MODE_SHORTER  3'h3
`define PST_MODE_STATE    3'h4
`define PST_PAT_LOW       2'h0
`define PST_PAT_HIGH      2'h1
`define PST_PAT_DONTCARE  2'h2
`endif

// ### hdl/pst_trigger.v
// pattern and state trigger qualifier for four comparator inputs
`timescale 1ns/100ps
`include "pst_consts.vh"
module pst_trigger (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [3:0]  cmp_level,
  input  wire [2:0]  trig_mode,
  input  wire [7:0]  pattern,
  input  wire [29:0] qual_cycles,
  input  wire [1:0]  edge_src,
  input  wire        edge_rising,
  input  wire        state_present,
  output reg         trig_pulse,
  output reg         pattern_true,
  output reg  [29:0] duration
);
  // comparator outputs are asynchronous to clk; thresholds live per input upstream
  wire [3:0]  sync_lvl;
  wire [3:0]  prev_lvl;
  wire [3:0]  pos_match;
  wire [3:0]  st_match;
  wire [29:0] qual_eff;
  wire [29:0] next_duration;
  wire        src_edge;
  wire        pat_now;
  wire        st_pat;
  wire        pat_enter;
  wire        pat_leave;
  wire        dur_long;
  wire        dur_short;
  reg         next_trig;

  // each input keeps its own synchroniser, so no level leans on a neighbour
  pst_in_stage u_in0 (
    .clk        (clk),
    .reset_n    (reset_n),
    .raw        (cmp_level[0]),
    .level      (sync_lvl[0]),
    .level_prev (prev_lvl[0])
  );

  pst_in_stage u_in1 (
    .clk        (clk),
    .reset_n    (reset_n),
    .raw        (cmp_level[1]),
    .level      (sync_lvl[1]),
    .level_prev (prev_lvl[1])
  );

  pst_in_stage u_in2 (
    .clk        (clk),
    .reset_n    (reset_n),
    .raw        (cmp_level[2]),
    .level      (sync_lvl[2]),
    .level_prev (prev_lvl[2])
  );

  pst_in_stage u_in3 (
    .clk        (clk),
    .reset_n    (reset_n),
    .raw        (cmp_level[3]),
    .level      (sync_lvl[3]),
    .level_prev (prev_lvl[3])
  );

  // the instance index doubles as the edge-source code of that position
  pst_pos_match #(
    .POS (2'h0)
  ) u_pos0 (
    .level    (sync_lvl[0]),
    .code     (pattern[1:0]),
    .edge_src (edge_src),
    .match    (pos_match[0]),
    .st_match (st_match[0])
  );

  pst_pos_match #(
    .POS (2'h1)
  ) u_pos1 (
    .level    (sync_lvl[1]),
    .code     (pattern[3:2]),
    .edge_src (edge_src),
    .match    (pos_match[1]),
    .st_match (st_match[1])
  );

  pst_pos_match #(
    .POS (2'h2)
  ) u_pos2 (
    .level    (sync_lvl[2]),
    .code     (pattern[5:4]),
    .edge_src (edge_src),
    .match    (pos_match[2]),
    .st_match (st_match[2])
  );

  pst_pos_match #(
    .POS (2'h3)
  ) u_pos3 (
    .level    (sync_lvl[3]),
    .code     (pattern[7:6]),
    .edge_src (edge_src),
    .match    (pos_match[3]),
    .st_match (st_match[3])
  );

  pst_edge_sel u_edge (
    .level       (sync_lvl),
    .level_prev  (prev_lvl),
    .edge_src    (edge_src),
    .edge_rising (edge_rising),
    .src_edge    (src_edge)
  );

  pst_qual_clamp u_clamp (
    .qual_cycles (qual_cycles),
    .qual_eff    (qual_eff)
  );

  pst_dur_next u_dur (
    .pat_now       (pat_now),
    .pat_enter     (pat_enter),
    .duration      (duration),
    .next_duration (next_duration)
  );

  assign pat_now   = &pos_match;
  assign st_pat    = &st_match;
  assign pat_enter = pat_now & ~pattern_true;
  assign pat_leave = ~pat_now & pattern_true;
  // duration is read before its update, so the exit cycle sees the full length
  assign dur_long  = duration >= qual_eff;
  assign dur_short = duration < qual_eff;

  // unused mode codes fall through to default and never fire
  always @* begin
    next_trig = 1'b0;
    case (trig_mode)
      `PST_MODE_ENTER: begin
        next_trig = pat_enter;
      end
      `PST_MODE_EXIT: begin
        next_trig = pat_leave;
      end
      `PST_MODE_LONGER: begin
        next_trig = pat_leave & dur_long;
      end
      `PST_MODE_SHORTER: begin
        next_trig = pat_leave & dur_short;
      end
      `PST_MODE_STATE: begin
        next_trig = src_edge & (st_pat == state_present);
      end
      default: begin
        next_trig = 1'b0;
      end
    endcase
  end

  // one clock of latency buys a glitch-free pulse and stable status
  always @(posedge clk) begin
    if (!reset_n) begin
      pattern_true <= 1'b0;
      duration     <= 30'h0;
      trig_pulse   <= 1'b0;
    end else begin
      pattern_true <= pat_now;
      duration     <= next_duration;
      trig_pulse   <= next_trig;
    end
  end
endmodule // pst_trigger

// two-flop synchroniser plus one history flop for a single comparator input
module pst_in_stage (
  input  wire clk,
  input  wire reset_n,
  input  wire raw,
  output wire level,
  output wire level_prev
);
  reg sync_a;
  reg sync_b;
  reg hist;

  // only sync_b reads sync_a, so a metastable first stage never reaches logic
  always @(posedge clk) begin
    if (!reset_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      hist   <= 1'b0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
      hist   <= sync_b;
    end
  end

  assign level      = sync_b;
  assign level_prev = hist;
endmodule // pst_in_stage

// one pattern position: must be high, must be low, or ignored
module pst_pos_match #(
  parameter [1:0] POS = 2'h0
) (
  input  wire       level,
  input  wire [1:0] code,
  input  wire [1:0] edge_src,
  output reg        match,
  output wire       st_match
);
  // both upper codes mean don't care, so no code is left undecoded
  always @* begin
    case (code)
      `PST_PAT_LOW: begin
        match = ~level;
      end
      `PST_PAT_HIGH: begin
        match = level;
      end
      default: begin
        match = 1'b1;
      end
    endcase
  end

  // the edge input's own code is ignored whatever it holds
  assign st_match = match | (edge_src == POS);
endmodule // pst_pos_match

// edge of the chosen polarity on the chosen input
module pst_edge_sel (
  input  wire [3:0] level,
  input  wire [3:0] level_prev,
  input  wire [1:0] edge_src,
  input  wire       edge_rising,
  output wire       src_edge
);
  wire src_now;
  wire src_was;
  wire rise;
  wire fall;

  // a high level held across reset release looks like a rising edge two clocks later
  assign src_now  = level[edge_src];
  assign src_was  = level_prev[edge_src];
  assign rise     = src_now & ~src_was;
  assign fall     = ~src_now & src_was;
  assign src_edge = edge_rising ? rise : fall;
endmodule // pst_edge_sel

// qualifier time pinned into the supported span
module pst_qual_clamp (
  input  wire [29:0] qual_cycles,
  output reg  [29:0] qual_eff
);
  // out-of-range settings are pinned rather than refused, so none is ignored
  always @* begin
    if (qual_cycles < `PST_QUAL_MIN_CYC) begin
      qual_eff = `PST_QUAL_MIN_CYC;
    end else if (qual_cycles > `PST_QUAL_MAX_CYC) begin
      qual_eff = `PST_QUAL_MAX_CYC;
    end else begin
      qual_eff = qual_cycles;
    end
  end
endmodule // pst_qual_clamp

// next value of the occurrence length counter
module pst_dur_next (
  input  wire        pat_now,
  input  wire        pat_enter,
  input  wire [29:0] duration,
  output reg  [29:0] next_duration
);
  wire at_ceiling;

  // saturating keeps a very long occurrence from wrapping into a short one
  assign at_ceiling = duration >= `PST_DUR_SAT;

  // the count includes the cycle of entry, so duration is cycles spent true
  always @* begin
    if (pat_enter) begin
      next_duration = 30'h1;
    end else if (pat_now && !at_ceiling) begin
      next_duration = duration + 30'h1;
    end else begin
      next_duration = duration;
    end
  end
endmodule // pst_dur_next

// ### tb/pst_cmp.sv
// comparator model, one threshold per input
`timescale 1ns/100ps
module pst_cmp (
  input  wire [31:0] sig,
  input  wire [31:0] thr,
  output reg  [3:0]  lvl
);
  integer i;
  always @* for (i = 0; i < 4; i++) lvl[i] = sig[8*i+:8] > thr[8*i+:8];
endmodule // pst_cmp

// ### tb/pst_trigger_assertions.sv
// port assertions for the trigger qualifier
`timescale 1ns/100ps
module pst_chk (
  input wire        clk,
  input wire        reset_n,
  input wire [3:0]  cmp_level,
  input wire [2:0]  trig_mode,
  input wire        trig_pulse,
  input wire        pattern_true,
  input wire [29:0] duration
);
  wire       t = trig_pulse;
  wire       p = pattern_true;
  wire [2:0] m = trig_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // outputs lag the mode by one edge, so the mode in force is its past value
  a_one_pulse: assert property ($stable(m) && t |=> !t) else $error("long pulse");
  a_enter_fire: assert property ($past(m) == 0 |-> t == $rose(p)) else $error("entry");
  a_exit_fire: assert property ($past(m) == 1 |-> t == $fell(p)) else $error("exit");
  a_qual_exit: assert property ($past(m) inside {2, 3} && t |-> $fell(p)) else $error("qual");
  a_state_edge: assert property ($past(m) == 4 && t |->
    $past(cmp_level, 3) != $past(cmp_level, 4)) else $error("state edge");
  a_idle_mode: assert property ($past(m) > 4 |-> !t) else $error("idle mode");
  a_dur_start: assert property ($rose(p) |-> duration == 1) else $error("dur start");
  a_dur_step: assert property (p && $past(p) |-> duration == $past(duration) + 1) else $error("dur");
endmodule // pst_chk
bind pst_trigger pst_chk chk (.clk, .reset_n, .cmp_level, .trig_mode, .trig_pulse,
  .pattern_true, .duration);

// ### tb/pst_trigger_tb.sv
// random bench comparing the qualifier with a cycle model
`timescale 1ns/100ps
`define CHK(n,e,g) begin n_checks++; if ((e) !== (g)) begin mismatches++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module pst_trigger_tb;
  reg         clk = 0, reset_n = 0, er = 0, sp = 0, mp = 0, mt = 0;
  reg  [31:0] sig = 0, thr = 0, s = 17016;
  reg  [3:0]  a = 0, b = 0, pb = 0;
  reg  [7:0]  pat = 0;
  reg  [29:0] q = 2;
  reg  [2:0]  mode = 0;
  reg  [1:0]  es = 0;
  wire [29:0] dur;
  wire [3:0]  lvl;
  wire        tp, pt;
  integer     md = 0, mismatches = 0, n_checks = 0, k;
  pst_cmp cmp (.sig, .thr, .lvl);
  pst_trigger dut (.clk, .reset_n, .cmp_level(lvl), .trig_mode(mode), .pattern(pat),
    .qual_cycles(q), .edge_src(es), .edge_rising(er), .state_present(sp), .trig_pulse(tp),
    .pattern_true(pt), .duration(dur));
  function [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function hit(input [3:0] v, input integer x);
    integer i;
    hit = 1;
    for (i = 0; i < 4; i++) if (!pat[2*i+1] && i != x && v[i] != pat[2*i]) hit = 0;
  endfunction
  task conclude;
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // model mirrors two sync stages plus the output register
  always @(posedge clk) if (!reset_n) {a, b, pb, mp, mt, md} <= 0; else begin
    a <= lvl;
    b <= a;
    pb <= b;
    mp <= hit(b, -1);
    md <= hit(b, -1) ? (mp ? md + 1 : 1) : md;
    case (mode)
      0: mt <= hit(b, -1) & !mp;
      1: mt <= !hit(b, -1) & mp;
      2: mt <= !hit(b, -1) & mp & md >= (q < 2 ? 2 : q);
      3: mt <= !hit(b, -1) & mp & md < (q < 2 ? 2 : q);
      4: mt <= b[es] != pb[es] && b[es] == er && hit(b, es) == sp;
      default: mt <= 0;
    endcase
  end
  always @(negedge clk) if (reset_n) begin
    `CHK("trig_pulse", mt, tp)
    `CHK("pattern_true", mp, pt)
    `CHK("duration", md[29:0], dur)
  end
  initial forever #2.5 clk = ~clk;
  initial begin #200000; mismatches++; conclude; end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1;
    // mode codes 0 to 5, unused code 5 included, with fresh pattern and thresholds
    for (k = 0; k < 60; k++) begin
      {sp, er, es, pat} <= rnd() >> 20;
      q <= rnd() % 10;
      mode <= 3'(k % 6);
      thr <= rnd();
      repeat (150) @(posedge clk) if (rnd() < 32'h30000000) sig <= rnd();
    end
    conclude;
  end
endmodule // pst_trigger_tb
